// file: verilog/adcis_pkg.sv
// Constants, types and state layout for the identity and status registers
package adcis_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [4:0] ADDR_IDENTITY = 5'h00;
  localparam logic [4:0] ADDR_FLAGS    = 5'h01;
  localparam logic [7:0] FLAGS_RESET   = 8'h80;

  // Field positions inside the flags and identity registers
  localparam int POR_BIT       = 7;
  localparam int NOT_READY_BIT = 6;
  localparam int MODEL_MSB     = 2;

  // Opcode field (bits 7:5) of the first command byte
  localparam logic [2:0] OP_READ  = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    PH_CMD    = 3'b000,
    PH_COUNT  = 3'b001,
    PH_READ   = 3'b010,
    PH_WRITE  = 3'b011,
    PH_IGNORE = 3'b100
  } adcis_phase_e;

  // Comparator outputs, in flags register order bits 5 down to 0
  typedef struct packed {
    logic pos_out_high_rail_flag;
    logic pos_out_low_rail_flag;
    logic neg_out_high_rail_flag;
    logic neg_out_low_rail_flag;
    logic ref_below_third_flag;
    logic ref_missing_flag;
  } adcis_monitor_s;

  typedef struct packed {
    logic           sclk_q;
    adcis_phase_e   phase;
    logic           is_write;
    logic [7:0]     rx;
    logic [2:0]     bitcnt;
    logic [4:0]     addr;
    logic [4:0]     remaining;
    logic [7:0]     tx;
    logic           miso;
    logic           miso_oe;
    logic           power_on_event_flag;
    logic           not_ready;
    adcis_monitor_s flags;
  } adcis_state_s;

  localparam adcis_state_s STATE_RESET = '{
    sclk_q:              1'b0,
    phase:               PH_CMD,
    is_write:            1'b0,
    rx:                  8'h00,
    bitcnt:              3'h0,
    addr:                5'h00,
    remaining:           5'h00,
    tx:                  8'h00,
    miso:                1'b0,
    miso_oe:             1'b0,
    power_on_event_flag: FLAGS_RESET[POR_BIT],
    not_ready:           FLAGS_RESET[NOT_READY_BIT],
    flags:               FLAGS_RESET[5:0]
  };

endpackage

// file: verilog/adcis_sync.sv
// Two-stage synchroniser for inputs from outside the mclk domain
`timescale 1ns/1ps
`default_nettype none

module adcis_sync #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } adcis_sync_s;

  adcis_sync_s r;
  adcis_sync_s next_r;

  // First stage feeds only the second
  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r <= '{s1: RESET_VAL, s2: RESET_VAL};
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign q = r.s2;

endmodule

`default_nettype wire

// file: verilog/adcis_regs.sv
// Identity and status registers behind the serial register commands
`timescale 1ns/1ps
`default_nettype none

module adcis_regs #(
  parameter logic [2:0] MODEL_ID    = 3'h6, // Arbitrary value
  parameter logic [4:0] ID_RESERVED = 5'h00 // Arbitrary value
) (
  // Clock, reset, enable
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  // Serial pins
  input  wire logic                     sclk,
  input  wire logic                     cs_n,
  input  wire logic                     mosi,
  output var  logic                     miso,
  output var  logic                     miso_oe,
  // Analog monitor comparators
  input  wire adcis_pkg::adcis_monitor_s monitor,
  // Same-domain configuration and start-up state
  input  wire logic                     rail_monitor_enable,
  input  wire logic [1:0]               ref_monitor_enable,
  input  wire logic                     startup_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [8:0]               pins_s;
  logic                     sclk_s;
  logic                     cs_n_s;
  logic                     mosi_s;
  adcis_pkg::adcis_monitor_s mon_s;

  // Reset value: deselected, link idle, monitors clear
  adcis_sync #(
    .W         (9),
    .RESET_VAL (9'h080)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({sclk, cs_n, mosi, monitor}),
    .q     (pins_s)
  );

  assign sclk_s = pins_s[8];
  assign cs_n_s = pins_s[7];
  assign mosi_s = pins_s[6];
  assign mon_s  = pins_s[5:0];

  ////////////////////////////////////////////////////////////////////////////
  // Monitor gating

  logic [5:0]      mon_enable;
  wire logic [5:0] mon_gated;

  // Rails share one enable; each reference level has its own
  assign mon_enable = {{4{rail_monitor_enable}}, ref_monitor_enable};

  // A disabled monitor reads zero whatever its comparator says
  for (genvar i = 0; i < 6; i++) begin : g_gate
    assign mon_gated[i] = mon_s[i] & mon_enable[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux

  adcis_pkg::adcis_state_s r;
  adcis_pkg::adcis_state_s next_r;

  function automatic logic [7:0] read_reg(input logic [4:0] a,
                                          input adcis_pkg::adcis_state_s s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      adcis_pkg::ADDR_IDENTITY: begin
        v[adcis_pkg::MODEL_MSB:0]   = MODEL_ID;
        v[7:adcis_pkg::MODEL_MSB+1] = ID_RESERVED;
      end
      adcis_pkg::ADDR_FLAGS: begin
        v[adcis_pkg::POR_BIT]           = s.power_on_event_flag;
        v[adcis_pkg::NOT_READY_BIT]     = s.not_ready;
        v[adcis_pkg::NOT_READY_BIT-1:0] = s.flags;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic       sclk_rise;
  logic       sclk_fall;
  logic [7:0] rx_byte;

  always_comb begin
    next_r    = r;
    sclk_rise = sclk_s & ~r.sclk_q;
    sclk_fall = ~sclk_s & r.sclk_q;
    rx_byte   = {r.rx[6:0], mosi_s};
    next_r.sclk_q = sclk_s;

    // Flags are live comparator state, not latched
    next_r.not_ready = startup_busy;
    next_r.flags     = mon_gated;

    if (cs_n_s) begin
      // Deselect aborts any command in flight
      next_r.phase   = adcis_pkg::PH_CMD;
      next_r.bitcnt  = 3'h0;
      next_r.tx      = 8'h00;
      next_r.miso_oe = 1'b0;
      next_r.rx      = 8'h00;
      next_r.addr    = 5'h00;
      next_r.is_write = 1'b0;
      next_r.remaining = 5'h00;
    end else begin
      next_r.miso_oe = 1'b1;
      if (sclk_rise) begin
        // Launch on rising edge so the host samples on falling
        next_r.miso = r.tx[7];
        next_r.tx   = {r.tx[6:0], 1'b0};
      end
      if (sclk_fall) begin
        next_r.rx     = rx_byte;
        next_r.bitcnt = r.bitcnt + 3'h1;
        if (r.bitcnt == 3'h7) begin
          case (r.phase)
            adcis_pkg::PH_CMD: begin
              next_r.addr = rx_byte[4:0];
              case (rx_byte[7:5])
                adcis_pkg::OP_READ: begin
                  next_r.phase    = adcis_pkg::PH_COUNT;
                  next_r.is_write = 1'b0;
                end
                adcis_pkg::OP_WRITE: begin
                  next_r.phase    = adcis_pkg::PH_COUNT;
                  next_r.is_write = 1'b1;
                end
                // Unknown opcodes idle out the frame
                default: next_r.phase = adcis_pkg::PH_IGNORE;
              endcase
            end
            adcis_pkg::PH_COUNT: begin
              // Low five bits give the byte count less one
              next_r.remaining = rx_byte[4:0];
              if (r.is_write) begin
                next_r.phase = adcis_pkg::PH_WRITE;
              end else begin
                next_r.phase = adcis_pkg::PH_READ;
                next_r.tx    = read_reg(r.addr, r);
              end
            end
            adcis_pkg::PH_READ: begin
              if (r.remaining == 5'h00) begin
                next_r.phase = adcis_pkg::PH_IGNORE;
              end else begin
                next_r.remaining = r.remaining - 5'h01;
                next_r.addr      = r.addr + 5'h01;
                next_r.tx        = read_reg(r.addr + 5'h01, r);
              end
            end
            adcis_pkg::PH_WRITE: begin
              // Only the power-on flag is writable; zero clears it
              if (r.addr == adcis_pkg::ADDR_FLAGS && !rx_byte[7]) begin
                next_r.power_on_event_flag = 1'b0;
              end
              if (r.remaining == 5'h00) begin
                next_r.phase = adcis_pkg::PH_IGNORE;
              end else begin
                next_r.remaining = r.remaining - 5'h01;
                next_r.addr      = r.addr + 5'h01;
              end
            end
            adcis_pkg::PH_IGNORE: begin
              next_r.phase = adcis_pkg::PH_IGNORE;
            end
            default: next_r.phase = adcis_pkg::PH_IGNORE;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Reset alone sets the power-on flag and clears all others
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r <= adcis_pkg::STATE_RESET;
    end else if (ce) begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign miso    = r.miso;
  assign miso_oe = r.miso_oe;

endmodule

`default_nettype wire

// file: testbench/adcis_regs_properties.sv
// Port checker for the register block
`timescale 1ns/1ps
`default_nettype none
module adcis_chk (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic miso_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_RST_IDLE: assert property (disable iff (1'b0)
    !rst_n && ce |=> !miso && !miso_oe) else $error("pins busy in reset");
  AST_OE_OFF: assert property (cs_n [*6] |-> !miso_oe)
    else $error("enable while idle");
  AST_SEL_LAT: assert property ($fell(cs_n) |-> ##[2:5] miso_oe)
    else $error("enable late");
  AST_OE_RISE: assert property ($rose(miso_oe) |->
    !$past(cs_n) && !$past(cs_n, 2)) else $error("enable unselected");
  AST_OE_FALL: assert property ($fell(miso_oe) |->
    $past(cs_n) && $past(cs_n, 2)) else $error("enable dropped early");
  // Data launches on the rise only, so it rests through the low half
  AST_MISO_HOLD: assert property (!cs_n && $fell(sclk) |->
    ##2 $stable(miso) [*3]) else $error("data moved in low half");
  AST_IDLE_MISO: assert property (cs_n [*7] |=> $stable(miso))
    else $error("data moved while idle");
  AST_FREEZE: assert property (!ce |=>
    $stable(miso) && $stable(miso_oe)) else $error("moved while frozen");
endmodule
bind adcis_regs adcis_chk chk_u (.mclk(mclk), .rst_n(rst_n), .ce(ce),
  .sclk(sclk), .cs_n(cs_n), .miso(miso), .miso_oe(miso_oe));
`default_nettype wire

// file: testbench/adcis_host.sv
// Host model issuing register commands on the serial pins
`timescale 1ns/1ps
`default_nettype none
module adcis_host (
  // Clock
  input  wire logic mclk,
  // Serial pins
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One frame of nbits; the clock stands low outside it
  task automatic xfer(input logic [31:0] w, input int nbits,
                      output logic [31:0] rd);
    logic [31:0] cap;
    cap = 32'h0000_0000;
    @(posedge mclk) #1 cs_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    for (int k = nbits - 1; k >= 0; k--) begin
      mosi = w[k];
      sclk = 1'b1;
      repeat (4) @(posedge mclk);
      #1 sclk = 1'b0;
      repeat (4) @(posedge mclk);
      #1 cap[k] = miso;
    end
    mosi = ~mosi;
    repeat (8) @(posedge mclk);
    #1 cs_n = 1'b1;
    repeat (8) @(posedge mclk);
    #1 rd = cap;
  endtask
endmodule
`default_nettype wire

// file: testbench/adc_id_status_registers_bench.sv
// Self-checking bench for the identity and status registers
`timescale 1ns/1ps
`default_nettype none
module adc_id_status_registers_bench;
  logic                      mclk = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      ce = 1'b1;
  logic                      rail_en = 1'b0;
  logic                      busy = 1'b0;
  logic [1:0]                ref_en = 2'b00;
  adcis_pkg::adcis_monitor_s mon = '0;
  logic                      sclk, cs_n, mosi, miso, miso_oe;
  logic [31:0]               rd;
  int                        bad_count = 0;
  int                        comparisons = 0;
  wire                       miso_pin = miso_oe ? miso : ~miso;
  always #2 mclk = ~mclk;
  // Model code is arbitrary
  localparam logic [2:0] MODEL_CODE = 3'h5;
  adcis_regs #(.MODEL_ID(MODEL_CODE)) dut_u (.mclk(mclk), .rst_n(rst_n),
    .ce(ce), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .monitor(mon), .rail_monitor_enable(rail_en),
    .ref_monitor_enable(ref_en), .startup_busy(busy));
  adcis_host host_u (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdf(input logic [4:0] a, input logic [7:0] exp);
    host_u.xfer({8'h00, adcis_pkg::OP_READ, a, 16'h0000}, 24, rd);
    check(rd[7:0], exp);
  endtask
  task automatic wrf(input logic [4:0] a, input logic [7:0] d);
    host_u.xfer({8'h00, adcis_pkg::OP_WRITE, a, 8'h00, d}, 24, rd);
  endtask
  task automatic close_out;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    #1 rst_n = 1'b1;
    rdf(adcis_pkg::ADDR_FLAGS, 8'h80);
    host_u.xfer({8'h00, adcis_pkg::OP_READ, adcis_pkg::ADDR_IDENTITY,
      16'h0000}, 24, rd);
    check(rd[7:0] & 8'h07, {5'h00, MODEL_CODE});
    wrf(5'h02, 8'hff);
    rdf(5'h02, 8'h00);
    $display("test reset values done");
    wrf(adcis_pkg::ADDR_FLAGS, 8'hff);
    rdf(adcis_pkg::ADDR_FLAGS, 8'h80);
    wrf(adcis_pkg::ADDR_FLAGS, 8'h00);
    rdf(adcis_pkg::ADDR_FLAGS, 8'h00);
    busy = 1'b1;
    rdf(adcis_pkg::ADDR_FLAGS, 8'h40);
    busy = 1'b0;
    $display("test flag access done");
    {rail_en, ref_en} = 3'h7;
    for (int i = 0; i < 6; i++) begin
      mon = 6'(1 << i);
      rdf(adcis_pkg::ADDR_FLAGS, 8'(1 << i));
    end
    mon = '1;
    for (int g = 0; g < 8; g++) begin
      {rail_en, ref_en} = 3'(g);
      rdf(adcis_pkg::ADDR_FLAGS, {2'b00, {4{rail_en}}, ref_en});
    end
    $display("test monitors done");
    ce = 1'b0;
    repeat (3) @(posedge mclk);
    #1 ce = 1'b1;
    mon = '0;
    rst_n = 1'b0;
    repeat (6) @(posedge mclk);
    #1 rst_n = 1'b1;
    rdf(adcis_pkg::ADDR_FLAGS, 8'h80);
    $display("test second reset done");
    // Unknown opcode shaped like a clearing write changes nothing
    host_u.xfer({8'h00, 3'h0, adcis_pkg::ADDR_FLAGS, 8'h00, 8'h00}, 24,
      rd);
    check(rd[7:0], 8'h00);
    // Frame cut inside the data byte drops the partial byte
    host_u.xfer({12'h000, adcis_pkg::OP_WRITE, adcis_pkg::ADDR_FLAGS,
      12'h000}, 20, rd);
    // Two-byte read walks from identity to flags
    host_u.xfer({adcis_pkg::OP_READ, adcis_pkg::ADDR_IDENTITY, 8'h01,
      16'h0000}, 32, rd);
    check(rd[15:8] & 8'h07, {5'h00, MODEL_CODE});
    check(rd[7:0], 8'h80);
    $display("test frame limits done");
    close_out;
  end
  // Run needs about 5800 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    close_out;
  end
endmodule
`default_nettype wire
